// *** configurable_gp_timer_core.sv ***
// Configurable general-purpose timer core with Avalon-MM register slave
//
// Function
// - Decode config field: 64-bit, unchained, watchdog, chained
// - Reset gives 64-bit counter, internal clock
// - 64/chained run needs both releases, style 01/10
// - Unchained halves run from own release and style
// - Style fields at 7:6 and 23:22, 00 off
// - 64-bit joins words; chained high prescales low
// - Unchained high half has 4-bit prescaler
// - Low clock: internal, gated, or external pin
// - Unchained high half always uses internal clock
// - External clock synchronised, optionally inverted first
// - Gated clock counts while input pin high
// - Pulse mode: 1-4 cycle pulse, invertible
// - Clock mode toggles output at each match
// - Low output to status and pin; high status only
// - One-shot: count to period, clear, stop
// - Continuous: clear after match, keep counting
// - Zero count and zero period never advance
// - Hardware reset restores all register defaults
// - Low release 0: status 0, pin floated
// - High release 0: high status 0
// - Clear counter the tick after period match
// - Match raises interrupt and event pulses
//
// Our own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "gp_timer_map.svh"
module configurable_gp_timer_core
  import gp_timer_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Timer pins
  input wire logic input_pin_in,
  output logic output_pin_out,
  output logic output_pin_oe_n_out,
  // Match events
  output logic low_match_interrupt_out,
  output logic low_match_event_out,
  output logic high_match_interrupt_out,
  output logic high_match_event_out
);

  // ============================================================
  // Storage
  logic [31:0] count_low_word; // Low counter
  logic [31:0] count_high_word; // High counter or prescaler
  logic [31:0] period_low_word; // Low period
  logic [31:0] period_high_word; // High period
  logic [31:0] counter_control_word; // Writable control bits
  logic [31:0] global_control_word; // Releases and config field
  logic [3:0] high_prescale_count; // Unchained prescale counter
  logic bus_ack; // Second cycle of an access
  logic low_hit; // Low or 64-bit count reached period
  logic high_hit; // Unchained high count reached period
  logic [1:0] status; // Shaped outputs, low in bit 0

  // ============================================================
  // Decoded fields
  config_t config_select_field;
  style_t low_enable_style;
  style_t high_enable_style;
  logic low_half_release;
  logic high_half_release;
  logic [3:0] high_prescale_ratio;
  logic low_clock_origin;
  logic low_input_gate_on;
  logic low_input_invert;

  assign config_select_field = config_t'(global_control_word[`GCW_CFG_MSB:`GCW_CFG_LSB]);
  assign low_half_release = global_control_word[`GCW_LOW_RELEASE];
  assign high_half_release = global_control_word[`GCW_HIGH_RELEASE];
  assign low_enable_style = style_t'(counter_control_word[`CCW_LOW_STYLE_LSB +: 2]);
  assign high_enable_style = style_t'(counter_control_word[`CCW_HIGH_STYLE_LSB +: 2]);
  assign high_prescale_ratio = counter_control_word[`CCW_RATIO_LSB +: 4];
  assign low_clock_origin = counter_control_word[`CCW_LOW_ORIGIN];
  assign low_input_gate_on = counter_control_word[`CCW_LOW_GATE_ON];
  assign low_input_invert = counter_control_word[`CCW_LOW_IN_INVERT];

  // ============================================================
  // Bus access strobes
  logic bus_req; // Any request pending
  logic bus_commit; // Edge where the access completes
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_prd_lo;
  logic wr_prd_hi;
  logic wr_ccw;
  logic wr_gcw;
  logic [31:0] be_mask; // Byte enables as a bit mask

  assign bus_req = avs_read_in | avs_write_in;
  assign bus_commit = bus_req & bus_ack;
  assign avs_waitrequest_out = bus_req & ~bus_ack; // One wait cycle per access
  assign be_mask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  // Address decode for writes; unmapped offsets are ignored
  always_comb begin
    wr_cnt_lo = 1'b0;
    wr_cnt_hi = 1'b0;
    wr_prd_lo = 1'b0;
    wr_prd_hi = 1'b0;
    wr_ccw = 1'b0;
    wr_gcw = 1'b0;
    if (avs_write_in && bus_ack) begin
      if (avs_address_in == `OFS_COUNT_LOW_WORD) begin
        wr_cnt_lo = 1'b1;
      end else if (avs_address_in == `OFS_COUNT_HIGH_WORD) begin
        wr_cnt_hi = 1'b1;
      end else if (avs_address_in == `OFS_PERIOD_LOW_WORD) begin
        wr_prd_lo = 1'b1;
      end else if (avs_address_in == `OFS_PERIOD_HIGH_WORD) begin
        wr_prd_hi = 1'b1;
      end else if (avs_address_in == `OFS_COUNTER_CONTROL_WORD) begin
        wr_ccw = 1'b1;
      end else if (avs_address_in == `OFS_GLOBAL_CONTROL_WORD) begin
        wr_gcw = 1'b1;
      end
    end
  end

  // Merge a byte-enabled write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // ============================================================
  // Run conditions
  logic joint_mode; // 64-bit or chained: one timer, two releases
  logic low_style_on;
  logic high_style_on;
  logic run_low;
  logic run_high;
  logic tick_low; // Low-half timer clock enable

  assign joint_mode = (config_select_field == CFG_GP64) || (config_select_field == CFG_CHAINED);
  assign low_style_on = (low_enable_style == STYLE_ONE_SHOT) || (low_enable_style == STYLE_CONTINUOUS);
  assign high_style_on = (high_enable_style == STYLE_ONE_SHOT) || (high_enable_style == STYLE_CONTINUOUS);
  // Watchdog selection falls through both terms, so nothing counts here
  assign run_low = joint_mode ? (low_half_release & high_half_release & low_style_on)
                   : ((config_select_field == CFG_UNCHAINED) & low_half_release & low_style_on);
  assign run_high = (config_select_field == CFG_UNCHAINED) & high_half_release & high_style_on;

  // Low clock source selection and pin conditioning
  gp_timer_input_cond u_input_cond (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .input_pin_in(input_pin_in),
    .clock_origin_in(low_clock_origin),
    .gate_on_in(low_input_gate_on),
    .input_invert_in(low_input_invert),
    .tick_out(tick_low)
  );

  // ============================================================
  // Counting steps for each configuration
  logic [63:0] cnt64;
  logic [63:0] prd64;
  logic [63:0] cnt64_inc;
  logic at64; // 64-bit count equals period
  logic step64; // 64-bit advance
  logic pre_step; // Chained prescaler advance
  logic pre_wrap; // Chained prescaler output clock
  logic step_lo; // 32-bit low advance
  logic at_lo;
  logic psc_wrap; // Unchained 4-bit prescaler output clock
  logic step_hi; // Unchained high advance
  logic at_hi;

  assign cnt64 = {count_high_word, count_low_word};
  assign prd64 = {period_high_word, period_low_word};
  assign cnt64_inc = cnt64 + 64'h0000_0000_0000_0001;
  assign at64 = (cnt64 == prd64);
  assign step64 = (config_select_field == CFG_GP64) & run_low & tick_low
                  & ~((cnt64 == 64'h0000_0000_0000_0000) & (prd64 == 64'h0000_0000_0000_0000));
  // High pair clocks the low pair once per prescale period
  assign pre_step = (config_select_field == CFG_CHAINED) & run_low & tick_low;
  assign pre_wrap = pre_step & (count_high_word == period_high_word);
  assign at_lo = (count_low_word == period_low_word);
  assign step_lo = (((config_select_field == CFG_CHAINED) & pre_wrap)
                    | ((config_select_field == CFG_UNCHAINED) & run_low & tick_low))
                   & ~((count_low_word == 32'h0000_0000) & (period_low_word == 32'h0000_0000));
  // High prescaler runs on the internal clock only
  assign psc_wrap = run_high & (high_prescale_count == high_prescale_ratio);
  assign at_hi = (count_high_word == period_high_word);
  assign step_hi = psc_wrap
                   & ~((count_high_word == 32'h0000_0000) & (period_high_word == 32'h0000_0000));

  // Period reached: count lands on period with this step
  assign low_hit = (step64 & (cnt64_inc == prd64))
                   | (step_lo & ((count_low_word + 32'h0000_0001) == period_low_word));
  assign high_hit = step_hi & ((count_high_word + 32'h0000_0001) == period_high_word);

  // ============================================================
  // Low counter word
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_low_word <= `RST_WORD;
    end else if (wr_cnt_lo) begin
      count_low_word <= merge(count_low_word, avs_writedata_in, be_mask);
    end else if (step64) begin
      count_low_word <= at64 ? 32'h0000_0000 : cnt64_inc[31:0];
    end else if (step_lo) begin
      count_low_word <= at_lo ? 32'h0000_0000 : count_low_word + 32'h0000_0001;
    end
  end

  // High counter word: upper 64-bit half, chained prescaler or own timer
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_high_word <= `RST_WORD;
    end else if (wr_cnt_hi) begin
      count_high_word <= merge(count_high_word, avs_writedata_in, be_mask);
    end else if (step64) begin
      count_high_word <= at64 ? 32'h0000_0000 : cnt64_inc[63:32];
    end else if (pre_step) begin
      count_high_word <= pre_wrap ? 32'h0000_0000 : count_high_word + 32'h0000_0001;
    end else if (step_hi) begin
      count_high_word <= at_hi ? 32'h0000_0000 : count_high_word + 32'h0000_0001;
    end
  end

  // Four-bit prescale counter of the unchained high half
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      high_prescale_count <= `RST_PSC;
    end else if (wr_ccw && avs_byteenable_in[3]) begin
      high_prescale_count <= avs_writedata_in[`CCW_PSC_LSB +: 4];
    end else if (psc_wrap) begin
      high_prescale_count <= 4'h0;
    end else if (run_high) begin
      high_prescale_count <= high_prescale_count + 4'h1;
    end
  end

  // ============================================================
  // Period words
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period_low_word <= `RST_WORD;
    end else if (wr_prd_lo) begin
      period_low_word <= merge(period_low_word, avs_writedata_in, be_mask);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      period_high_word <= `RST_WORD;
    end else if (wr_prd_hi) begin
      period_high_word <= merge(period_high_word, avs_writedata_in, be_mask);
    end
  end

  // ============================================================
  // Control words; a finished one-shot clears its own style field
  logic stop_lo; // One-shot low or joint timer wraps
  logic stop_hi; // One-shot high half wraps

  assign stop_lo = (low_enable_style == STYLE_ONE_SHOT) & ((step64 & at64) | (step_lo & at_lo));
  assign stop_hi = (high_enable_style == STYLE_ONE_SHOT) & step_hi & at_hi;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      counter_control_word <= `RST_WORD; // Internal clock, styles off
    end else begin
      if (wr_ccw) begin
        counter_control_word <= merge(counter_control_word, avs_writedata_in, be_mask & `CCW_WRITE_MASK);
      end else begin
        // A software write in the same cycle takes priority over the stop
        if (stop_lo) begin
          counter_control_word[`CCW_LOW_STYLE_LSB +: 2] <= STYLE_OFF;
        end
        if (stop_hi) begin
          counter_control_word[`CCW_HIGH_STYLE_LSB +: 2] <= STYLE_OFF;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      global_control_word <= `RST_WORD; // 64-bit configuration
    end else if (wr_gcw) begin
      global_control_word <= merge(global_control_word, avs_writedata_in, be_mask & `GCW_WRITE_MASK);
    end
  end

  // ============================================================
  // Output shapers, one per half
  logic [1:0] match_q; // Registered match pulses
  logic [1:0] sh_release;
  logic [1:0] sh_shape;
  logic [1:0] sh_invert;
  logic [3:0] sh_width;

  assign sh_release = {high_half_release, low_half_release};
  assign sh_shape = {counter_control_word[`CCW_HIGH_SHAPE], counter_control_word[`CCW_LOW_SHAPE]};
  assign sh_invert = {counter_control_word[`CCW_HIGH_OUT_INVERT], counter_control_word[`CCW_LOW_OUT_INVERT]};
  assign sh_width = {counter_control_word[`CCW_HIGH_PWID_LSB +: 2], counter_control_word[`CCW_LOW_PWID_LSB +: 2]};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      match_q <= 2'b00;
    end else begin
      match_q <= {high_hit, low_hit};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_half
      gp_timer_out_shaper u_shaper (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .release_in(sh_release[g]),
        .shape_in(sh_shape[g]),
        .invert_in(sh_invert[g]),
        .width_in(sh_width[2*g +: 2]),
        .match_in(match_q[g]),
        .status_out(status[g])
      );
    end
  endgenerate

  // Interrupt and event pulses share the match instant
  assign low_match_interrupt_out = match_q[0];
  assign low_match_event_out = match_q[0];
  assign high_match_interrupt_out = match_q[1];
  assign high_match_event_out = match_q[1];

  // Low output reaches the pin; pin floats while the low half is held
  assign output_pin_out = status[0];
  assign output_pin_oe_n_out = ~low_half_release;

  // ============================================================
  // Read data, captured in the wait cycle and held through the commit edge
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address_in == `OFS_COUNT_LOW_WORD) begin
      rd_mux = count_low_word;
    end else if (avs_address_in == `OFS_COUNT_HIGH_WORD) begin
      rd_mux = count_high_word;
    end else if (avs_address_in == `OFS_PERIOD_LOW_WORD) begin
      rd_mux = period_low_word;
    end else if (avs_address_in == `OFS_PERIOD_HIGH_WORD) begin
      rd_mux = period_high_word;
    end else if (avs_address_in == `OFS_COUNTER_CONTROL_WORD) begin
      rd_mux = counter_control_word;
      rd_mux[`CCW_PSC_LSB +: 4] = high_prescale_count;
      rd_mux[`CCW_LOW_STATUS] = status[0];
      rd_mux[`CCW_HIGH_STATUS] = status[1];
    end else if (avs_address_in == `OFS_GLOBAL_CONTROL_WORD) begin
      rd_mux = global_control_word;
    end
  end

  // Access sequencer: first cycle waits, second completes
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !bus_ack) begin
      avs_readdata_out <= rd_mux;
    end
  end

endmodule

// *** gp_timer_map.svh ***
// Register offsets, field positions and reset values of the timer core
`ifndef GP_TIMER_MAP_SVH
`define GP_TIMER_MAP_SVH

// ============================================================
// Register byte offsets on the Avalon-MM slave
`define OFS_COUNT_LOW_WORD 5'h00
`define OFS_COUNT_HIGH_WORD 5'h04
`define OFS_PERIOD_LOW_WORD 5'h08
`define OFS_PERIOD_HIGH_WORD 5'h0C
`define OFS_COUNTER_CONTROL_WORD 5'h10
`define OFS_GLOBAL_CONTROL_WORD 5'h14

// ============================================================
// Global control word fields
`define GCW_LOW_RELEASE 0
`define GCW_HIGH_RELEASE 1
`define GCW_CFG_LSB 2
`define GCW_CFG_MSB 3
`define GCW_WRITE_MASK 32'h0000_000F

// ============================================================
// Counter control word fields
`define CCW_LOW_STATUS 0
`define CCW_LOW_GATE_ON 1
`define CCW_LOW_OUT_INVERT 2
`define CCW_LOW_SHAPE 3
`define CCW_LOW_PWID_LSB 4
`define CCW_LOW_STYLE_LSB 6
`define CCW_LOW_ORIGIN 8
`define CCW_LOW_IN_INVERT 9
`define CCW_HIGH_STATUS 16
`define CCW_HIGH_OUT_INVERT 18
`define CCW_HIGH_SHAPE 19
`define CCW_HIGH_PWID_LSB 20
`define CCW_HIGH_STYLE_LSB 22
`define CCW_RATIO_LSB 24
`define CCW_PSC_LSB 28
`define CCW_WRITE_MASK 32'h0FFC_03FE

// ============================================================
// Reset values
`define RST_WORD 32'h0000_0000
`define RST_PSC 4'h0

`endif

// *** gp_timer_pkg.sv ***
// Types shared by the timer core files
package gp_timer_pkg;

  // Configuration select encodings
  typedef enum logic [1:0] {
    CFG_GP64 = 2'b00,
    CFG_UNCHAINED = 2'b01,
    CFG_WATCHDOG = 2'b10,
    CFG_CHAINED = 2'b11
  } config_t;

  // Enable style encodings
  typedef enum logic [1:0] {
    STYLE_OFF = 2'b00,
    STYLE_ONE_SHOT = 2'b01,
    STYLE_CONTINUOUS = 2'b10,
    STYLE_SPARE = 2'b11
  } style_t;

endpackage

// *** gp_timer_input_cond.sv ***
// Input pin conditioner: synchroniser, inversion and low-half tick selection
`timescale 1ns/1ns
module gp_timer_input_cond (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pin and selection
  input wire logic input_pin_in,
  input wire logic clock_origin_in,
  input wire logic gate_on_in,
  input wire logic input_invert_in,
  // Timer clock enable for the low half
  output logic tick_out
);

  logic sync_a; // First stage, read only by sync_b
  logic sync_b; // Second stage, safe to use
  logic ext_last; // Previous conditioned external level

  // ============================================================
  // Two-stage synchroniser
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= input_pin_in;
      sync_b <= sync_a;
    end
  end

  // Edge memory for the external clock, inversion applied first
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_last <= 1'b0;
    end else begin
      ext_last <= sync_b ^ input_invert_in;
    end
  end

  // Tick source: external rising edge, gated internal, or plain internal
  always_comb begin
    if (clock_origin_in) begin
      tick_out = (sync_b ^ input_invert_in) & ~ext_last;
    end else if (gate_on_in) begin
      tick_out = sync_b; // Counts while the pin stays high
    end else begin
      tick_out = 1'b1;
    end
  end

endmodule

// *** gp_timer_out_shaper.sv ***
// Output shaper for one half: pulse mode with optional inversion, or clock mode
`timescale 1ns/1ns
module gp_timer_out_shaper (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Controls
  input wire logic release_in,
  input wire logic shape_in,
  input wire logic invert_in,
  input wire logic [1:0] width_in,
  input wire logic match_in,
  // Shaped output
  output logic status_out
);

  logic [2:0] pulse_left; // Remaining pulse cycles
  logic clk_level; // Clock-mode level
  logic shaped; // Level before release hold

  // ============================================================
  // Pulse counter, reloaded on each match
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pulse_left <= 3'h0;
    end else if (!release_in) begin
      pulse_left <= 3'h0;
    end else if (match_in) begin
      pulse_left <= {1'b0, width_in} + 3'h1; // 1 to 4 cycles
    end else if (pulse_left != 3'h0) begin
      pulse_left <= pulse_left - 3'h1;
    end
  end

  // Clock-mode level toggles at each match
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clk_level <= 1'b0;
    end else if (!release_in) begin
      clk_level <= 1'b0;
    end else if (match_in) begin
      clk_level <= ~clk_level;
    end
  end

  // Inversion applies to pulse mode only
  assign shaped = shape_in ? clk_level : ((pulse_left != 3'h0) ^ invert_in);

  // Registered output, forced low while the half is held in reset
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status_out <= 1'b0;
    end else begin
      status_out <= release_in & shaped;
    end
  end

endmodule

// *** gp_timer_monitor.sv ***
// Port checker of the timer core
`timescale 1ns/1ns
module gp_timer_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Register bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Pin and events
  input wire logic output_pin_oe_n_out,
  input wire logic low_match_interrupt_out,
  input wire logic low_match_event_out,
  input wire logic high_match_interrupt_out,
  input wire logic high_match_event_out
);
  // ==========================================
  // Single clock domain, so one default clocking
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========================================
  // Bus handshake
  idle_no_wait_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest high with no request");
  first_wait_a: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
    else $error("no wait cycle at request start");
  one_wait_a: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("more than one wait cycle");
  // ==========================================
  // Match events travel as pairs, one cycle each
  low_pair_a: assert property (low_match_interrupt_out == low_match_event_out)
    else $error("low interrupt and event differ");
  high_pair_a: assert property (high_match_interrupt_out == high_match_event_out)
    else $error("high interrupt and event differ");
  low_single_a: assert property (low_match_interrupt_out |=> !low_match_interrupt_out)
    else $error("low match pulse longer than one cycle");
  high_single_a: assert property (high_match_interrupt_out |=> !high_match_interrupt_out)
    else $error("high match pulse longer than one cycle");
  // Pin enable follows only a committed register write
  pin_float_a: assert property ($changed(output_pin_oe_n_out) |-> $past(avs_write_in && !avs_waitrequest_out))
    else $error("pin enable moved without a write");
endmodule
bind configurable_gp_timer_core gp_timer_monitor i_gp_timer_monitor (.clk_in, .rstn_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .output_pin_oe_n_out, .low_match_interrupt_out,
  .low_match_event_out, .high_match_interrupt_out, .high_match_event_out);

// *** tb_top.sv ***
// Self-checking bench of the timer core
`timescale 1ns/1ns
`include "gp_timer_map.svh"
module tb_top;
  // ==========================================
  // Bench signals
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [4:0] adr = 5'h00;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic pin = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wait_q, pin_o, oe_n, li, hi;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int c, h, p;
  localparam logic [4:0] ofs_cl = `OFS_COUNT_LOW_WORD;
  localparam logic [4:0] ofs_pl = `OFS_PERIOD_LOW_WORD;
  localparam logic [4:0] ofs_ph = `OFS_PERIOD_HIGH_WORD;
  localparam logic [4:0] ofs_cw = `OFS_COUNTER_CONTROL_WORD;
  localparam logic [4:0] ofs_gw = `OFS_GLOBAL_CONTROL_WORD;
  // Byte lanes all on: partial writes are not exercised
  configurable_gp_timer_core i_configurable_gp_timer_core (.clk_in, .rstn_in, .avs_address_in(adr),
    .avs_read_in(rd_q), .avs_write_in(wr_q), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_q), .input_pin_in(pin), .output_pin_out(pin_o),
    .output_pin_oe_n_out(oe_n), .low_match_interrupt_out(li), .low_match_event_out(),
    .high_match_interrupt_out(hi), .high_match_event_out());
  // ==========================================
  // Clock and hang guard
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      test_done;
    end
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until waitrequest seen low; an idle cycle follows
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    adr <= a;
    wdat <= d;
    wr_q <= 1'b1;
    do @(posedge clk_in); while (wait_q !== 1'b0);
    wr_q <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    adr <= a;
    rd_q <= 1'b1;
    do @(posedge clk_in); while (wait_q !== 1'b0);
    chk("readdata", rdat, e);
    rd_q <= 1'b0;
    @(posedge clk_in);
  endtask
  // Counts low and high match pulses over a window
  task automatic cnt(input int n);
    c = 0;
    h = 0;
    p = 0;
    repeat (n) begin
      @(negedge clk_in);
      c += int'(li === 1'b1);
      p += int'(pin_o === 1'b1);
      h += int'(hi === 1'b1);
    end
    @(posedge clk_in);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // Test sequence
  initial begin
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    // Defaults, last address unmapped
    for (int i = 0; i < 7; i++) rd(5'(i * 4), 32'h0000_0000);
    chk("oe_n", 32'(oe_n), 32'h0000_0001);
    // 64-bit continuous, period 2, one release then both
    wr(ofs_pl, 32'h0000_0002);
    wr(ofs_cw, 32'h0000_0088);
    wr(ofs_gw, 32'h0000_0001);
    cnt(12);
    chk("low pulses", c, 0);
    wr(ofs_gw, 32'h0000_0003);
    chk("oe_n", 32'(oe_n), 32'h0000_0000);
    cnt(30);
    chk("low pulses", c, 10);
    chk("high pulses", h, 0);
    chk("pin clock", p, 15);
    // Gated internal clock
    wr(ofs_gw, 32'h0000_0000);
    chk("oe_n", 32'(oe_n), 32'h0000_0001);
    wr(ofs_cl, 32'h0000_0000);
    wr(ofs_cw, 32'h0000_0092);
    wr(ofs_gw, 32'h0000_0003);
    cnt(20);
    chk("gated pulses", c, 0);
    pin <= 1'b1;
    cnt(6);
    cnt(30);
    chk("gated pulses", c, 10);
    chk("pin pulse", p, 20);
    // One-shot clears its style and count
    wr(ofs_gw, 32'h0000_0000);
    pin <= 1'b0;
    wr(ofs_cl, 32'h0000_0000);
    wr(ofs_cw, 32'h0000_0040);
    wr(ofs_gw, 32'h0000_0003);
    cnt(20);
    chk("one-shot pulses", c, 1);
    rd(ofs_cw, 32'h0000_0000);
    rd(ofs_cl, 32'h0000_0000);
    // External clock on the pin: two rising edges give two steps
    wr(ofs_gw, 32'h0000_0000);
    repeat (8) @(posedge clk_in);
    wr(ofs_cw, 32'h0000_0180);
    wr(ofs_gw, 32'h0000_0003);
    repeat (4) begin
      pin <= ~pin;
      repeat (4) @(posedge clk_in);
    end
    rd(ofs_cl, 32'h0000_0002);
    // Zero count and zero period: a one-shot must not finish
    wr(ofs_gw, 32'h0000_0000);
    wr(ofs_cl, 32'h0000_0000);
    wr(ofs_pl, 32'h0000_0000);
    wr(ofs_cw, 32'h0000_0040);
    wr(ofs_gw, 32'h0000_0003);
    cnt(20);
    chk("zero pulses", c, 0);
    rd(ofs_cw, 32'h0000_0040);
    // Unchained high half, ratio 1 and period 1 give one match in four
    wr(ofs_gw, 32'h0000_0000);
    wr(ofs_ph, 32'h0000_0001);
    wr(ofs_cw, 32'h0180_0000);
    wr(ofs_gw, 32'h0000_0006);
    cnt(40);
    chk("high pulses", h, 10);
    chk("low pulses", c, 0);
    // Watchdog selection idles the core
    wr(ofs_gw, 32'h0000_000B);
    cnt(20);
    chk("watchdog pulses", c + h, 0);
    test_done;
  end
endmodule
